// >>> core/tcsi_channel.sv
// Register-facing part of one 16-bit timer channel: values, sticky flags, mirrors and interrupt mask
//
// Behaviour
// - Counter register reads live 16-bit count, upper zero
// - A and B read-only in capture, writable in waveform
// - A and B reads return current content immediately
// - C readable and writable in both modes
// - Bit 0 sets on overflow, clears on status read
// - Bit 1 flags double load without read, capture only
// - Bits 2,3 flag A/B compare in waveform only
// - Bit 4 flags C compare in both modes
// - Bits 5,6 flag A/B capture load, capture only
// - Bit 7 flags external trigger, clears on read
// - Bit 16 shows counter clock enabled state
// - Bit 17 mirrors line A, pin or driven
// - Bit 18 mirrors line B, pin or driven
// - Enable register ones set mask bits
// - Disable register ones clear mask bits
// - Mask register reads enabled sources
// - Mode bit 0 capture, 1 waveform
//
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns
module tcsi_channel
   import tcsi_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [15:0] counter_now_i,
   input wire logic count_step_i,
   input wire logic overflow_i,
   input wire logic capture_a_i,
   input wire logic capture_b_i,
   input wire logic ext_trigger_i,
   input wire logic counter_clock_on_i,
   input wire logic drive_a_i,
   input wire logic drive_b_i,
   input wire logic channel_line_a_i,
   input wire logic channel_line_b_i,
   output logic waveform_mode_o,
   output logic [15:0] reg_a_value_o,
   output logic [15:0] reg_b_value_o,
   output logic [15:0] reg_c_value_o,
   output logic irq_o
);

   // ****************************************
   // Helper functions
   // ****************************************
   // Merge a bus write into a 16-bit register by byte lane
   function automatic logic [15:0] tcsi_merge16(input logic [15:0] old_v, input logic [31:0] wdata,
                                                input logic [3:0] be);
      logic [15:0] res;
      res = old_v;
      if (be[0])
      begin
         res[7:0] = wdata[7:0];
      end
      if (be[1])
      begin
         res[15:8] = wdata[15:8];
      end
      return res;
   endfunction

   // Flags valid in the current mode
   function automatic logic [7:0] tcsi_valid(input logic wave);
      logic [7:0] res;
      res = wave ? ~TCSI_CAPTURE_ONLY : ~TCSI_WAVE_ONLY;
      return res;
   endfunction

   // ****************************************
   // Declarations
   // ****************************************
   tcsi_avs_req_t req;
   logic ack_q;
   logic acc_rd;
   logic acc_wr;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic wave_q;
   logic [15:0] reg_a_q;
   logic [15:0] reg_b_q;
   logic [15:0] reg_c_q;
   logic unread_a_q;
   logic unread_b_q;
   tcsi_evt_t flags_q;
   tcsi_evt_t flags_d;
   tcsi_evt_t evt_set;
   logic [7:0] flag_clr;
   logic [7:0] mask_q;
   logic [1:0] line_a_sync_q;
   logic [1:0] line_b_sync_q;
   logic line_a_level;
   logic line_b_level;
   logic load_a;
   logic load_b;
   logic [31:0] status_word;

   assign req.address = avs_address_i;
   assign req.read = avs_read_i;
   assign req.write = avs_write_i;
   assign req.writedata = avs_writedata_i;
   assign req.byteenable = avs_byteenable_i;

   // ****************************************
   // Avalon-MM handshake
   // ****************************************
   // Every access answers one cycle after it is presented
   assign avs_waitrequest_o = (req.read | req.write) & ~ack_q;
   assign acc_rd = req.read & ack_q;
   assign acc_wr = req.write & ack_q;

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         ack_q <= 1'b0;
      end
      else
      begin
         ack_q <= (req.read | req.write) & ~ack_q;
      end
   end

   // ****************************************
   // Mode bit
   // ****************************************
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         wave_q <= TCSI_MODE_RST;
      end
      else if (acc_wr && req.address == TCSI_OFF_MODE && req.byteenable[0])
      begin
         wave_q <= req.writedata[TCSI_MODE_WAVE_BIT];
      end
   end

   assign waveform_mode_o = wave_q;

   // ****************************************
   // Registers A, B and C
   // ****************************************
   // Captures only happen in capture mode
   assign load_a = capture_a_i & ~wave_q;
   assign load_b = capture_b_i & ~wave_q;

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         reg_a_q <= TCSI_REG_RST;
      end
      else if (load_a)
      begin
         reg_a_q <= counter_now_i;
      end
      else if (acc_wr && wave_q && req.address == TCSI_OFF_REG_A)
      begin
         reg_a_q <= tcsi_merge16(reg_a_q, req.writedata, req.byteenable);
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         reg_b_q <= TCSI_REG_RST;
      end
      else if (load_b)
      begin
         reg_b_q <= counter_now_i;
      end
      else if (acc_wr && wave_q && req.address == TCSI_OFF_REG_B)
      begin
         reg_b_q <= tcsi_merge16(reg_b_q, req.writedata, req.byteenable);
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         reg_c_q <= TCSI_REG_RST;
      end
      else if (acc_wr && req.address == TCSI_OFF_REG_C)
      begin
         reg_c_q <= tcsi_merge16(reg_c_q, req.writedata, req.byteenable);
      end
   end

   assign reg_a_value_o = reg_a_q;
   assign reg_b_value_o = reg_b_q;
   assign reg_c_value_o = reg_c_q;

   // Unread tracking for load overrun; a new load wins over a read in the same cycle
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         unread_a_q <= 1'b0;
         unread_b_q <= 1'b0;
      end
      else
      begin
         unread_a_q <= load_a | (unread_a_q & ~(acc_rd && req.address == TCSI_OFF_REG_A));
         unread_b_q <= load_b | (unread_b_q & ~(acc_rd && req.address == TCSI_OFF_REG_B));
      end
   end

   // ****************************************
   // Line synchronisers
   // ****************************************
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         line_a_sync_q <= 2'h0;
         line_b_sync_q <= 2'h0;
      end
      else
      begin
         line_a_sync_q <= {line_a_sync_q[0], channel_line_a_i};
         line_b_sync_q <= {line_b_sync_q[0], channel_line_b_i};
      end
   end

   assign line_a_level = wave_q ? drive_a_i : line_a_sync_q[1];
   assign line_b_level = wave_q ? drive_b_i : line_b_sync_q[1];

   // ****************************************
   // Sticky event flags
   // ****************************************
   always_comb
   begin
      evt_set.overflow_flag = overflow_i;
      evt_set.load_overrun_flag = (load_a & unread_a_q) | (load_b & unread_b_q);
      evt_set.cmp_a_flag = count_step_i & (counter_now_i == reg_a_q);
      evt_set.cmp_b_flag = count_step_i & (counter_now_i == reg_b_q);
      evt_set.cmp_c_flag = count_step_i & (counter_now_i == reg_c_q);
      evt_set.load_a_flag = load_a;
      evt_set.load_b_flag = load_b;
      evt_set.ext_trigger_flag = ext_trigger_i;
   end

   // Status read clears all event flags; a write of ones clears the chosen ones
   always_comb
   begin
      flag_clr = 8'h00;
      if (acc_rd && req.address == TCSI_OFF_SR)
      begin
         flag_clr = 8'hff;
      end
      else if (acc_wr && req.address == TCSI_OFF_SR && req.byteenable[0])
      begin
         flag_clr = req.writedata[7:0];
      end
      // Set wins over clear; flags of the other mode never set
      flags_d = tcsi_evt_t'(((flags_q & ~flag_clr) | evt_set) & tcsi_valid(wave_q));
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         flags_q <= tcsi_evt_t'(TCSI_FLAG_RST);
      end
      else
      begin
         flags_q <= flags_d;
      end
   end

   // ****************************************
   // Interrupt mask
   // ****************************************
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         mask_q <= TCSI_MASK_RST;
      end
      else if (acc_wr && req.byteenable[0] && req.address == TCSI_OFF_IER)
      begin
         mask_q <= mask_q | req.writedata[7:0];
      end
      else if (acc_wr && req.byteenable[0] && req.address == TCSI_OFF_IDR)
      begin
         mask_q <= mask_q & ~req.writedata[7:0];
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         irq_o <= 1'b0;
      end
      else
      begin
         irq_o <= |(flags_d & mask_q);
      end
   end

   // ****************************************
   // Read data
   // ****************************************
   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[7:0] = flags_q & tcsi_valid(wave_q);
      status_word[TCSI_SR_CLK_BIT] = counter_clock_on_i;
      status_word[TCSI_SR_LINE_A_BIT] = line_a_level;
      status_word[TCSI_SR_LINE_B_BIT] = line_b_level;
   end

   // Sampled in the waiting cycle, stands through the answering edge
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      case (req.address)
         TCSI_OFF_MODE: rdata_d[TCSI_MODE_WAVE_BIT] = wave_q;
         TCSI_OFF_COUNT: rdata_d[15:0] = counter_now_i;
         TCSI_OFF_REG_A: rdata_d[15:0] = load_a ? counter_now_i : reg_a_q;
         TCSI_OFF_REG_B: rdata_d[15:0] = load_b ? counter_now_i : reg_b_q;
         TCSI_OFF_REG_C: rdata_d[15:0] = reg_c_q;
         TCSI_OFF_SR: rdata_d = status_word;
         TCSI_OFF_IMR: rdata_d[7:0] = mask_q;
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         rdata_q <= 32'h0000_0000;
      end
      else if (req.read && !ack_q)
      begin
         rdata_q <= rdata_d;
      end
   end

   assign avs_readdata_o = rdata_q;

endmodule

// >>> pkg/tcsi_pkg.sv
// Constants, field layout and carrier types of the timer channel register block
package tcsi_pkg;

   // ****************************************
   // Register byte addresses
   // ****************************************
   localparam logic [7:0] TCSI_OFF_MODE = 8'h04;
   localparam logic [7:0] TCSI_OFF_COUNT = 8'h10;
   localparam logic [7:0] TCSI_OFF_REG_A = 8'h14;
   localparam logic [7:0] TCSI_OFF_REG_B = 8'h18;
   localparam logic [7:0] TCSI_OFF_REG_C = 8'h1c;
   localparam logic [7:0] TCSI_OFF_SR = 8'h20;
   localparam logic [7:0] TCSI_OFF_IER = 8'h24;
   localparam logic [7:0] TCSI_OFF_IDR = 8'h28;
   localparam logic [7:0] TCSI_OFF_IMR = 8'h2c;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int TCSI_MODE_WAVE_BIT = 0;
   localparam int TCSI_SR_CLK_BIT = 16;
   localparam int TCSI_SR_LINE_A_BIT = 17;
   localparam int TCSI_SR_LINE_B_BIT = 18;

   // ****************************************
   // Values after reset
   // ****************************************
   localparam logic TCSI_MODE_RST = 1'h0;
   localparam logic [15:0] TCSI_REG_RST = 16'h0000;
   localparam logic [7:0] TCSI_FLAG_RST = 8'h00;
   localparam logic [7:0] TCSI_MASK_RST = 8'h00;

   // Flags that only mean something in one mode
   localparam logic [7:0] TCSI_CAPTURE_ONLY = 8'h62;
   localparam logic [7:0] TCSI_WAVE_ONLY = 8'h0c;

   // ****************************************
   // Carrier types
   // ****************************************
   // Sticky event flags, laid out as status bits 7 down to 0
   typedef struct packed {
      logic ext_trigger_flag;
      logic load_b_flag;
      logic load_a_flag;
      logic cmp_c_flag;
      logic cmp_b_flag;
      logic cmp_a_flag;
      logic load_overrun_flag;
      logic overflow_flag;
   } tcsi_evt_t;

   // Avalon-MM slave request
   typedef struct packed {
      logic [7:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } tcsi_avs_req_t;

endpackage

// >>> dv/tcsi_channel_assertions.sv
// Concurrent checks on the timer channel register port
`timescale 1ns/1ns
module tcsi_channel_assertions
   import tcsi_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic [15:0] counter_now_i,
   input wire logic capture_a_i,
   input wire logic counter_clock_on_i,
   input wire logic waveform_mode_o,
   input wire logic [15:0] reg_a_value_o,
   input wire logic [15:0] reg_c_value_o,
   input wire logic irq_o
);
   // ****************************************
   // Accepting edges and checks
   // ****************************************
   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (reset_i);
   wire rd_ok = avs_read_i && !avs_waitrequest_o;
   wire wr_ok = avs_write_i && !avs_waitrequest_o;
   wire sr_rd = rd_ok && avs_address_i == TCSI_OFF_SR;

   a_wait_once: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("read not answered after one wait cycle");
   a_count_live: assert property (rd_ok && avs_address_i == TCSI_OFF_COUNT |->
      avs_readdata_o == {16'h0000, $past(counter_now_i)}) else $error("counter read wrong");
   // A capture in the sampling cycle is returned at once
   a_reg_a_read: assert property (rd_ok && avs_address_i == TCSI_OFF_REG_A |->
      avs_readdata_o == {16'h0000, (($past(capture_a_i) && !$past(waveform_mode_o)) ? $past(counter_now_i) :
      $past(reg_a_value_o))}) else $error("register A read wrong");
   a_reg_c_read: assert property (rd_ok && avs_address_i == TCSI_OFF_REG_C |->
      avs_readdata_o == {16'h0000, $past(reg_c_value_o)}) else $error("register C read wrong");
   a_reg_a_locked: assert property (wr_ok && avs_address_i == TCSI_OFF_REG_A && !waveform_mode_o &&
      !capture_a_i |=> $stable(reg_a_value_o)) else $error("register A written in capture mode");
   a_reg_a_written: assert property (wr_ok && avs_address_i == TCSI_OFF_REG_A && waveform_mode_o |=>
      reg_a_value_o == $past(avs_writedata_i[15:0])) else $error("register A write lost");
   a_clk_shown: assert property (sr_rd |->
      avs_readdata_o[16] == $past(counter_clock_on_i)) else $error("clock status bit wrong");
   a_capture_quiet: assert property (sr_rd && !$past(waveform_mode_o) |->
      (avs_readdata_o[7:0] & TCSI_WAVE_ONLY) == 8'h00) else $error("compare flag in capture mode");
   a_wave_quiet: assert property (sr_rd && $past(waveform_mode_o) |->
      (avs_readdata_o[7:0] & TCSI_CAPTURE_ONLY) == 8'h00) else $error("load flag in waveform mode");

   c_cmp_c: cover property (sr_rd && avs_readdata_o[4]);
   c_wave_reg_a: cover property (rd_ok && avs_address_i == TCSI_OFF_REG_A && waveform_mode_o);
   c_irq: cover property ($rose(irq_o));
endmodule

// >>> dv/tcsi_line_model.sv
// Far-side model of the two channel I/O lines
`timescale 1ns/1ns
module tcsi_line_model
(
   input wire logic ref_clk_i,
   input wire logic level_a_i,
   input wire logic level_b_i,
   output logic channel_line_a_o = 1'b0,
   output logic channel_line_b_o = 1'b1
);
   // Pins move off the device edge, as an unrelated outside source would
   always @(negedge ref_clk_i)
   begin
      channel_line_a_o <= level_a_i;
      channel_line_b_o <= level_b_i;
   end
endmodule

// >>> dv/tcsi_channel_tb.sv
// Self-checking bench of the timer channel register block
`timescale 1ns/1ns
module tcsi_channel_tb
   import tcsi_pkg::*;
;
   logic ref_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [7:0] avs_address_i = 8'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'hf;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic [15:0] counter_now_i = 16'h0000;
   logic count_step_i = 1'b0;
   logic overflow_i = 1'b0;
   logic capture_a_i = 1'b0;
   logic capture_b_i = 1'b0;
   logic ext_trigger_i = 1'b0;
   logic counter_clock_on_i = 1'b1;
   logic drive_a_i = 1'b1;
   logic drive_b_i = 1'b0;
   logic channel_line_a_i;
   logic channel_line_b_i;
   logic waveform_mode_o;
   logic [15:0] reg_a_value_o;
   logic [15:0] reg_b_value_o;
   logic [15:0] reg_c_value_o;
   logic irq_o;
   logic pa = 1'b0;
   logic pb = 1'b1;
   logic [31:0] q;
   logic [15:0] v;
   int bad_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   int unsigned seed = 95;

   tcsi_channel tcsi_channel_i (.ref_clk_i, .reset_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .counter_now_i,
      .count_step_i, .overflow_i, .capture_a_i, .capture_b_i, .ext_trigger_i, .counter_clock_on_i,
      .drive_a_i, .drive_b_i, .channel_line_a_i, .channel_line_b_i, .waveform_mode_o,
      .reg_a_value_o, .reg_b_value_o, .reg_c_value_o, .irq_o);
   tcsi_line_model tcsi_line_model_i (.ref_clk_i, .level_a_i(pa), .level_b_i(pb),
      .channel_line_a_o(channel_line_a_i), .channel_line_b_o(channel_line_b_i));

   initial
      forever #50 ref_clk_i = ~ref_clk_i;

   always @(posedge ref_clk_i)
   begin
      cycles++;
      if (cycles > 3000)
      begin
         bad_count++;
         close_out();
      end
   end

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [15:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction

   // Status word expected for flags f; mirrors follow the mode w
   function automatic logic [31:0] sr(input logic [7:0] f, input logic w);
      return {13'h0000, w ? drive_b_i : pb, w ? drive_a_i : pa, counter_clock_on_i, 8'h00, f};
   endfunction

   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      avs_read_i <= !w;
      avs_write_i <= w;
      avs_address_i <= a;
      avs_writedata_i <= d;
      do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask

   task automatic wr32(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask

   // Bits: trigger, load B, load A, overflow, count step
   task automatic pulse(input logic [4:0] p);
      @(posedge ref_clk_i);
      {ext_trigger_i, capture_b_i, capture_a_i, overflow_i, count_step_i} <= p;
      @(posedge ref_clk_i);
      {ext_trigger_i, capture_b_i, capture_a_i, overflow_i, count_step_i} <= 5'h00;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      repeat (6) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      chk_rd(TCSI_OFF_SR, sr(8'h00, 1'b0));
      chk_rd(TCSI_OFF_IMR, 32'h0);
      chk_rd(8'h3c, 32'h0);
      $display("test 1 done");
      repeat (4)
      begin
         v = xs();
         counter_now_i <= v;
         chk_rd(TCSI_OFF_COUNT, {16'h0000, v});
         wr32(TCSI_OFF_REG_C, {xs(), v});
         chk_rd(TCSI_OFF_REG_C, {16'h0000, v});
         wr32(TCSI_OFF_REG_A, {16'h0000, ~v});
         chk_rd(TCSI_OFF_REG_A, 32'h0);
      end
      // Upper byte lane alone
      avs_byteenable_i <= 4'h2;
      wr32(TCSI_OFF_REG_C, 32'h0000_5678);
      avs_byteenable_i <= 4'hf;
      chk_rd(TCSI_OFF_REG_C, {16'h0000, 8'h56, v[7:0]});
      $display("test 2 done");
      v = xs();
      counter_now_i <= v;
      pa <= 1'b1;
      pb <= 1'b0;
      pulse(5'h04);
      chk_rd(TCSI_OFF_REG_A, {16'h0000, v});
      chk_rd(TCSI_OFF_SR, sr(8'h20, 1'b0));
      chk_rd(TCSI_OFF_SR, sr(8'h00, 1'b0));
      pulse(5'h1a);
      pulse(5'h08);
      chk_rd(TCSI_OFF_SR, sr(8'hc3, 1'b0));
      wr32(TCSI_OFF_REG_C, {16'h0000, v});
      pulse(5'h01);
      chk_rd(TCSI_OFF_SR, sr(8'h10, 1'b0));
      $display("test 3 done");
      drive_a_i <= 1'b0;
      drive_b_i <= 1'b1;
      wr32(TCSI_OFF_MODE, 32'h1);
      v = xs();
      wr32(TCSI_OFF_REG_A, {16'h0000, v});
      wr32(TCSI_OFF_REG_B, {16'h0000, ~v});
      chk_rd(TCSI_OFF_REG_A, {16'h0000, v});
      chk_rd(TCSI_OFF_REG_B, {16'h0000, ~v});
      chk({16'h0000, reg_b_value_o}, {16'h0000, ~v});
      counter_now_i <= v;
      pulse(5'h05);
      counter_now_i <= ~v;
      pulse(5'h01);
      chk_rd(TCSI_OFF_SR, sr(8'h0c, 1'b1));
      chk_rd(TCSI_OFF_REG_A, {16'h0000, v});
      $display("test 4 done");
      wr32(TCSI_OFF_IER, 32'h81);
      wr32(TCSI_OFF_IER, 32'h0);
      chk_rd(TCSI_OFF_IMR, 32'h81);
      pulse(5'h10);
      repeat (2) @(negedge ref_clk_i);
      chk({31'h0, irq_o}, 32'h1);
      wr32(TCSI_OFF_IDR, 32'h80);
      wr32(TCSI_OFF_IDR, 32'h0);
      chk_rd(TCSI_OFF_IMR, 32'h01);
      counter_clock_on_i <= 1'b0;
      @(negedge ref_clk_i);
      chk({31'h0, irq_o}, 32'h0);
      chk_rd(TCSI_OFF_SR, sr(8'h80, 1'b1));
      $display("test 5 done");
      // Writing ones to the status register clears only those flags
      pulse(5'h12);
      wr32(TCSI_OFF_SR, 32'h80);
      chk_rd(TCSI_OFF_SR, sr(8'h01, 1'b1));
      chk_rd(TCSI_OFF_SR, sr(8'h00, 1'b1));
      $display("test 6 done");
      reset_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      chk_rd(TCSI_OFF_IMR, 32'h0);
      chk_rd(TCSI_OFF_REG_A, 32'h0);
      $display("test 7 done");
      close_out();
   end
endmodule

bind tcsi_channel tcsi_channel_assertions tcsi_channel_assertions_i (.ref_clk_i, .reset_i, .avs_address_i,
   .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .counter_now_i,
   .capture_a_i, .counter_clock_on_i, .waveform_mode_o, .reg_a_value_o, .reg_c_value_o, .irq_o);
